// file: rtl/sys_bus_write_sequencer.sv
// Write-side sequencer of a multiplexed address/data system bus.
// Assumes one bus clock, synchronous inputs and an agent pacing writes by write_ready_n.
// Assumes the mode word is steady around reset release; it is taken once, on the first edge after.
// Reserved write mode code runs as legacy; the pipeline clock ratio is only reported, not used.
// Outputs are registered; valid_out_n_o is low on every address and data cycle.
// Overview of operation
// (R1) Re-issue mode launches a write at most every two bus clocks.
// (R2) Pipelined mode launches every two clocks; one write may follow ready loss; the code launches at most every three clocks.
// (R3) Block write: four 64-bit beats, or eight 32-bit beats.
// (R4) On 32-bit bus, single writes over four bytes split into two transfers.
// (R5) Zero to seven idle clocks between write address and data, reset-time field.
// (R6) Delay code zero gives legacy timing: data directly after address.
// (R7) Same delay applies to block and single writes.
// (R8) Single writes of one byte to bus width, plus eight-word blocks.
// (R9) Pipeline clock ratio two to eight, fixed at reset.
// (R10) Delay read from mode bits 15 to 17; code n gives n idle clocks.
// (R11) Write mode: 00 legacy, 10 pipelined, 11 re-issue, 01 reserved.
// (R12) Mode bit 12: zero for 64-bit bus, one for 32-bit bus.
// (R13) Agent asserts write_ready_n low only when it can accept a write.
// (R14) Pipelined: after ready loss, one extra write, then hold until ready.
// (R15) Mode source never selects reserved write mode or ratio codes.
module sys_bus_write_sequencer (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [wr_seq_pkg::MODE_WIDTH-1:0] mode_word_i,
	input wire logic req_valid_i,
	input wire logic req_block_i,
	input wire logic [3:0] req_size_i,
	input wire logic [31:0] req_addr_i,
	input wire logic [63:0] req_data_i,
	input wire logic write_ready_n_i,
	output logic req_ready_o,
	output logic [63:0] sys_addr_data_bus_o,
	output logic valid_out_n_o,
	output logic addr_phase_o,
	output logic last_beat_o,
	output logic [3:0] pipeline_clock_ratio_o,
	output logic bus_is_32_o
);
	import wr_seq_pkg::*;

	// Decoded reset-time mode settings
	wr_mode_if mode ();

	// Mode word taken once after reset
	wr_mode_latch u_mode (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.mode_word_i(mode_word_i),
		.mode(mode)
	);

	// All sequencer state, registered as one word
	typedef struct packed {
		phase_type phase;
		logic [2:0] gap_cnt;
		logic [3:0] beats_left;
		logic half_hi;
		logic split;
		logic extra_used;
		logic [1:0] spacing;
		logic [31:0] addr;
		logic [63:0] data;
		logic req_ready;
		logic [63:0] bus;
		logic valid_n;
		logic addr_phase;
		logic last_beat;
		logic [3:0] ratio;
		logic is32;
	} seq_type;

	// Registered state and its next value
	seq_type state_q, state_d;

	// True when a new write may start under the selected write mode
	function automatic logic may_launch(input logic [1:0] wmode, input logic rdy_n, input logic extra,
			input logic [1:0] spacing);
		logic ok;
		ok = 1'b0;
		case (wmode)
			WMODE_REISSUE: ok = !rdy_n && spacing == 2'h0; // [R1]
			WMODE_PIPE: ok = (!rdy_n || !extra) && spacing == 2'h0; // [R2] [R14]
			WMODE_LEGACY: ok = !rdy_n; // [R11]
			WMODE_RSVD: ok = !rdy_n; // Reserved code runs as legacy [R15]
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : may_launch

	// Number of data beats of the transfer about to start
	function automatic logic [3:0] beat_count(input logic block, input logic is32, input logic [3:0] size);
		logic [3:0] n;
		n = 4'h1;
		if (block) begin
			n = is32 ? BLOCK_BEATS_32 : BLOCK_BEATS_64; // [R3] [R8]
		end else if (split_needed(block, is32, size)) begin
			n = 4'h2; // [R4]
		end
		return n;
	endfunction : beat_count

	// A single write wider than one word needs two transfers on a 32-bit bus
	function automatic logic split_needed(input logic block, input logic is32, input logic [3:0] size);
		return !block && is32 && size > WORD_BYTES; // [R4]
	endfunction : split_needed

	// Bus value of one data beat: full width, or the low then the high word
	function automatic logic [63:0] beat_word(input logic [63:0] data, input logic is32, input logic hi);
		logic [63:0] w;
		w = data;
		if (is32) begin
			w = {32'h0, hi ? data[63:32] : data[31:0]}; // [R3] [R4]
		end
		return w;
	endfunction : beat_word

	// Bus value of an address cycle; the upper half stays quiet
	function automatic logic [63:0] addr_word(input logic [31:0] addr);
		return {32'h0, addr};
	endfunction : addr_word

	// Start and resume decisions for the state machine
	logic launch_ok;
	logic resume_ok;
	assign launch_ok = mode.valid && req_valid_i &&
			may_launch(mode.wr_mode, write_ready_n_i, state_q.extra_used, state_q.spacing); // [R1] [R2]
	assign resume_ok = !write_ready_n_i && state_q.spacing == 2'h0; // [R13]

	// Next-state logic for the write sequence
	always_comb begin
		state_d = state_q;
		state_d.req_ready = 1'b0;
		state_d.valid_n = 1'b1;
		state_d.addr_phase = 1'b0;
		state_d.last_beat = 1'b0;
		state_d.ratio = mode.clk_ratio; // [R9]
		state_d.is32 = mode.bus_is_32; // [R12]
		// Spacing counter toward the next launch
		if (state_q.spacing != 2'h0) begin
			state_d.spacing = state_q.spacing - 2'h1;
		end
		// Pipelined mode re-arms its spare write once ready returns
		if (!write_ready_n_i) begin
			state_d.extra_used = 1'b0; // [R14]
		end
		case (state_q.phase)
			ST_IDLE: begin
				// Take the request when the write mode lets it start
				if (launch_ok) begin
					state_d.req_ready = 1'b1;
					state_d.addr = req_addr_i;
					state_d.data = req_data_i;
					state_d.beats_left = beat_count(req_block_i, mode.bus_is_32, req_size_i);
					state_d.split = split_needed(req_block_i, mode.bus_is_32, req_size_i); // [R4]
					state_d.half_hi = 1'b0;
					if (write_ready_n_i) begin
						state_d.extra_used = 1'b1; // [R2] [R14]
					end
					state_d.phase = ST_ADDR;
				end
			end
			ST_ADDR: begin
				// Address cycle, then the idle gap or the data
				state_d.bus = addr_word(state_q.addr);
				state_d.valid_n = 1'b0;
				state_d.addr_phase = 1'b1;
				state_d.spacing = REPEAT_CYCLES - 2'h1; // [R1] [R2]
				state_d.gap_cnt = mode.wr_delay; // [R5] [R7] [R10]
				state_d.phase = (mode.wr_delay == 3'h0) ? ST_DATA : ST_GAP; // [R6]
			end
			ST_GAP: begin
				// Idle bus clocks between address and data
				state_d.gap_cnt = state_q.gap_cnt - 3'h1; // [R5]
				if (state_q.gap_cnt == 3'h1) begin
					state_d.phase = ST_DATA;
				end
			end
			ST_DATA: begin
				// One data beat; a 32-bit bus alternates low and high words
				state_d.valid_n = 1'b0;
				state_d.bus = beat_word(state_q.data, state_q.is32, state_q.half_hi);
				if (state_q.is32) begin
					state_d.half_hi = !state_q.half_hi;
				end
				state_d.beats_left = state_q.beats_left - 4'h1; // [R3]
				if (state_q.beats_left == 4'h1) begin
					state_d.last_beat = 1'b1;
					state_d.phase = ST_IDLE;
				end else if (state_q.split) begin
					// Second half of a split single goes as its own transfer
					state_d.addr = state_q.addr + 32'h4; // [R4]
					state_d.phase = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Second half waits for the agent before its own address
				if (resume_ok) begin // [R13]
					state_d.phase = ST_ADDR;
				end
			end
			default: begin
				state_d.phase = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= '{phase: ST_IDLE, valid_n: 1'b1, default: '0};
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state register
	assign req_ready_o = state_q.req_ready;
	assign sys_addr_data_bus_o = state_q.bus;
	assign valid_out_n_o = state_q.valid_n;
	assign addr_phase_o = state_q.addr_phase;
	assign last_beat_o = state_q.last_beat;
	assign pipeline_clock_ratio_o = state_q.ratio;
	assign bus_is_32_o = state_q.is32;
endmodule : sys_bus_write_sequencer

// file: rtl/wr_mode_if.sv
// Carrier for the decoded reset-time mode settings.
// Assumes a producer that latches them once after reset.
interface wr_mode_if;
	logic bus_is_32;
	logic [2:0] wr_delay;
	logic [1:0] wr_mode;
	logic [3:0] clk_ratio;
	logic valid;
	modport source (output bus_is_32, wr_delay, wr_mode, clk_ratio, valid);
	modport sink (input bus_is_32, wr_delay, wr_mode, clk_ratio, valid);
endinterface : wr_mode_if

// file: rtl/wr_mode_latch.sv
// Latches the reset-time mode word into decoded fields.
// Assumes the mode word is stable around reset release.
module wr_mode_latch (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [wr_seq_pkg::MODE_WIDTH-1:0] mode_word_i,
	wr_mode_if.source mode
);
	import wr_seq_pkg::*;

	typedef struct packed {
		logic taken;
		logic bus_is_32;
		logic [2:0] wr_delay;
		logic [1:0] wr_mode;
		logic [3:0] clk_ratio;
	} latch_type;

	latch_type state_q, state_d;

	// Capture once, on the first edge after reset release
	always_comb begin
		state_d = state_q;
		if (!state_q.taken) begin
			state_d.taken = 1'b1;
			state_d.bus_is_32 = mode_word_i[WIDTH32_BIT]; // [R12]
			state_d.wr_delay = mode_word_i[DELAY_LSB +: 3]; // [R5] [R10]
			state_d.wr_mode = mode_word_i[WMODE_LSB +: 2]; // [R11]
			state_d.clk_ratio = RATIO_BASE + {1'b0, mode_word_i[RATIO_LSB +: 3]}; // [R9]
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign mode.bus_is_32 = state_q.bus_is_32;
	assign mode.wr_delay = state_q.wr_delay;
	assign mode.wr_mode = state_q.wr_mode;
	assign mode.clk_ratio = state_q.clk_ratio;
	assign mode.valid = state_q.taken;
endmodule : wr_mode_latch

// file: rtl/wr_seq_pkg.sv
// Constants and types shared by the write sequencer files.
// Assumes a single bus clock domain; mode fields are sampled once after reset.
package wr_seq_pkg;
	// Mode field positions inside the reset-time mode word
	localparam int MODE_WIDTH = 27;
	localparam int WMODE_LSB = 9;
	localparam int WIDTH32_BIT = 12;
	localparam int DELAY_LSB = 15;
	localparam int RATIO_LSB = 5;
	// Non-block write mode codes
	localparam logic [1:0] WMODE_LEGACY = 2'h0;
	localparam logic [1:0] WMODE_RSVD = 2'h1;
	localparam logic [1:0] WMODE_PIPE = 2'h2;
	localparam logic [1:0] WMODE_REISSUE = 2'h3;
	// Clock ratio base: code 0 means a ratio of two
	localparam logic [3:0] RATIO_BASE = 4'h2;
	// Data beats of one cache line block
	localparam logic [3:0] BLOCK_BEATS_64 = 4'h4;
	localparam logic [3:0] BLOCK_BEATS_32 = 4'h8;
	// Bytes carried by one 32-bit beat
	localparam logic [3:0] WORD_BYTES = 4'h4;
	// Least spacing between write launches, in bus clocks
	localparam logic [1:0] REPEAT_CYCLES = 2'h2;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_GAP, ST_DATA, ST_WAIT} phase_type;

endpackage : wr_seq_pkg

// file: tb/sys_bus_write_sequencer_bench.sv
// Bench sending random writes through the sequencer to a pacing agent.
// Assumes the checker binds itself to the design.
module sys_bus_write_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import wr_seq_pkg::*;
	logic sys_clk_i = 0, reset_n_i = 0, req_valid_i = 0, req_block_i = 0, slow = 0;
	logic [MODE_WIDTH-1:0] mode_word_i = '0;
	logic [3:0] req_size_i = 4'h1, pipeline_clock_ratio_o;
	logic [31:0] req_addr_i = '0, rnd = 32'hfc5c;
	logic [63:0] req_data_i = '0, sys_addr_data_bus_o;
	logic write_ready_n_i, req_ready_o, valid_out_n_o, addr_phase_o, last_beat_o, bus_is_32_o;
	int errors = 0, n_tests = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	sys_bus_write_sequencer sys_bus_write_sequencer_inst (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.mode_word_i(mode_word_i),
		.req_valid_i(req_valid_i),
		.req_block_i(req_block_i),
		.req_size_i(req_size_i),
		.req_addr_i(req_addr_i),
		.req_data_i(req_data_i),
		.write_ready_n_i(write_ready_n_i),
		.req_ready_o(req_ready_o),
		.sys_addr_data_bus_o(sys_addr_data_bus_o),
		.valid_out_n_o(valid_out_n_o),
		.addr_phase_o(addr_phase_o),
		.last_beat_o(last_beat_o),
		.pipeline_clock_ratio_o(pipeline_clock_ratio_o),
		.bus_is_32_o(bus_is_32_o)
	);
	wr_agent wr_agent_inst (.sys_clk_i, .reset_n_i, .slow_i(slow), .write_ready_n_o(write_ready_n_i));
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic summarize;
		if (errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Data beats a write takes on the configured bus
	function automatic logic [3:0] beats(input logic blk, input logic [3:0] sz);
		if (blk) return mode_word_i[WIDTH32_BIT] ? BLOCK_BEATS_32 : BLOCK_BEATS_64;
		return mode_word_i[WIDTH32_BIT] && sz > WORD_BYTES ? 4'h2 : 4'h1;
	endfunction : beats
	// Expected bus value of data beat n: full width, or low then high word
	function automatic logic [63:0] beat_exp(input logic [63:0] d, input logic [3:0] n);
		if (!mode_word_i[WIDTH32_BIT]) return d;
		return {32'h0, n[0] ? d[63:32] : d[31:0]};
	endfunction : beat_exp
	task automatic tick;
		@(posedge sys_clk_i);
		#1;
	endtask : tick
	// Offer one write, then count its address and data cycles
	task automatic xfer(input logic blk, input logic [3:0] sz);
		logic [3:0] na = 4'h0, nb = 4'h0, eb = beats(blk, sz);
		rnd = lfsr(rnd);
		{slow, req_valid_i, req_block_i, req_size_i} = {rnd[4], 1'b1, blk, sz};
		req_addr_i = {rnd[31:3], 3'h0};
		req_data_i = {~rnd, rnd};
		for (int k = 0; k < 200 && req_ready_o !== 1'b1; k++) tick();
		cmp(req_ready_o, 1'b1);
		tick();
		req_valid_i = 0;
		for (int k = 0; k < 300 && nb < eb; k++) begin
			if (addr_phase_o === 1'b1)
				cmp(sys_addr_data_bus_o, {32'h0, req_addr_i + {26'h0, na, 2'h0}});
			if (valid_out_n_o === 1'b0 && addr_phase_o === 1'b0)
				cmp(sys_addr_data_bus_o, beat_exp(req_data_i, nb));
			na += 4'(addr_phase_o === 1'b1);
			nb += 4'(valid_out_n_o === 1'b0 && addr_phase_o === 1'b0);
			if (nb < eb) tick();
		end
		cmp(last_beat_o, 1'b1);
		cmp(nb, eb);
		cmp(na, blk ? 4'h1 : eb);
		if (nb != eb) summarize();
	endtask : xfer
	// Each pass resets into a new mode, then runs corner and random writes
	initial begin
		for (int c = 0; c < 8; c++) begin
			reset_n_i = 0;
			mode_word_i = '0;
			mode_word_i[WIDTH32_BIT] = c[0];
			mode_word_i[WMODE_LSB+:2] = c % 3 == 0 ? WMODE_LEGACY : c % 3 == 1 ? WMODE_PIPE : WMODE_REISSUE;
			mode_word_i[DELAY_LSB+:3] = c[2:0];
			mode_word_i[RATIO_LSB+:3] = 3'(c % 7);
			repeat (10) tick();
			reset_n_i = 1;
			repeat (2) tick();
			cmp(bus_is_32_o, c[0]);
			cmp(pipeline_clock_ratio_o, RATIO_BASE + 4'(c % 7));
			xfer(1'b1, 4'h8);
			xfer(1'b0, 4'h8);
			xfer(1'b0, 4'h4);
			repeat (8) xfer(rnd[5], 4'h1 + 4'(rnd[2:0]));
		end
		summarize();
	end
endmodule : sys_bus_write_sequencer_bench

// file: tb/wr_agent.sv
// Far-side agent model that paces writes by an active-low ready.
// Assumes the bench picks prompt or slow pacing per write.
module wr_agent (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic slow_i,
	output logic write_ready_n_o
);
	logic [1:0] cnt_q;
	// Not ready in reset; a slow agent is busy half the time
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
		if (!reset_n_i) {cnt_q, write_ready_n_o} <= 3'h1;
		else {cnt_q, write_ready_n_o} <= {cnt_q + 2'h1, slow_i & cnt_q[1]};
endmodule : wr_agent

// file: tb/wr_seq_asserts.sv
// Checker of write sequencing at the sequencer's ports.
// Assumes mode_word_i only changes while reset is held.
module wr_seq_asserts (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [wr_seq_pkg::MODE_WIDTH-1:0] mode_word_i,
	input wire logic req_block_i,
	input wire logic [3:0] req_size_i,
	input wire logic [31:0] req_addr_i,
	input wire logic write_ready_n_i,
	input wire logic req_ready_o,
	input wire logic [63:0] sys_addr_data_bus_o,
	input wire logic valid_out_n_o,
	input wire logic addr_phase_o,
	input wire logic last_beat_o
);
	import wr_seq_pkg::*;
	logic [3:0] gap_q, beats_q;
	logic [1:0] hi_q;
	logic blk_q;
	logic [31:0] addr_q;
	wire logic w32 = mode_word_i[WIDTH32_BIT];
	wire logic [3:0] dly = {1'b0, mode_word_i[DELAY_LSB+:3]};
	wire logic beat = !valid_out_n_o && !addr_phase_o;
	wire logic [3:0] line = w32 ? BLOCK_BEATS_32 : BLOCK_BEATS_64;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Clocks and beats since address, writes taken while not ready
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
		if (!reset_n_i) {gap_q, beats_q, hi_q} <= 10'h3c0;
		else begin
			gap_q <= addr_phase_o ? 4'h1 : gap_q + 4'(gap_q != 4'hf);
			beats_q <= addr_phase_o ? 4'h0 : beats_q + 4'(beat);
			hi_q <= !write_ready_n_i ? 2'h0 : hi_q + 2'(req_ready_o && $past(write_ready_n_i));
		end
	// Request captured as it is taken
	always_ff @(posedge sys_clk_i)
		if (req_ready_o) {blk_q, addr_q} <= {req_block_i, req_addr_i};
	sequence s_second;
		##[2:90] addr_phase_o && sys_addr_data_bus_o[31:0] == addr_q + 32'h4;
	endsequence
	AST_READY: assert property (req_ready_o && mode_word_i[WMODE_LSB+:2] != WMODE_PIPE |-> !$past(write_ready_n_i))
		else $error("taken while not ready");
	AST_EXTRA: assert property (hi_q < 2'h2) else $error("two writes while not ready");
	AST_SPACE: assert property (addr_phase_o |=> !addr_phase_o) else $error("addresses too close");
	AST_IDLE: assert property (gap_q <= dly |-> valid_out_n_o) else $error("data too early");
	AST_DATA: assert property (gap_q == dly + 4'h1 |-> beat) else $error("data too late");
	AST_BEATS: assert property (last_beat_o |-> beat && beats_q == (blk_q ? line - 4'h1 : 4'h0))
		else $error("wrong beat count");
	AST_ADDR: assert property (req_ready_o |=> addr_phase_o && sys_addr_data_bus_o[31:0] == addr_q)
		else $error("address cycle wrong");
	AST_SPLIT: assert property (req_ready_o && w32 && !req_block_i && req_size_i > WORD_BYTES |=> s_second)
		else $error("second transfer missing");
endmodule : wr_seq_asserts
bind sys_bus_write_sequencer wr_seq_asserts wr_seq_asserts_inst (
	.sys_clk_i(sys_clk_i),
	.reset_n_i(reset_n_i),
	.mode_word_i(mode_word_i),
	.req_block_i(req_block_i),
	.req_size_i(req_size_i),
	.req_addr_i(req_addr_i),
	.write_ready_n_i(write_ready_n_i),
	.req_ready_o(req_ready_o),
	.sys_addr_data_bus_o(sys_addr_data_bus_o),
	.valid_out_n_o(valid_out_n_o),
	.addr_phase_o(addr_phase_o),
	.last_beat_o(last_beat_o)
);
